// >>> hba_regs.svh
// Constants for the Harvard bus arbiter and peripheral bridge
`ifndef HBA_REGS_SVH
`define HBA_REGS_SVH

`define HBA_DATA_W 32
`define HBA_HALF_W 16
`define HBA_PADDR_W 22
`define HBA_DADDR_W 32
`define HBA_PER_ADDR_W 16

// Requester slots, in falling priority order
`define HBA_NREQ 6
`define HBA_IX_DW 0
`define HBA_IX_PW 1
`define HBA_IX_DR 2
`define HBA_IX_PR 3
`define HBA_IX_IF 4
`define HBA_IX_ACC 5

// Target decode: address bits select one of four targets
`define HBA_NTGT 4
`define HBA_NMEM 3
`define HBA_TGT_MSB 17
`define HBA_TGT_LSB 16
`define HBA_TGT_SHARED 2'h1
`define HBA_TGT_PER 2'h3

// Peripheral frame select inside the peripheral window
`define HBA_FRAME_MSB 15
`define HBA_FRAME_LSB 14
`define HBA_FRAME1 2'h1
`define HBA_FRAME2 2'h2
`define HBA_FRAME3 2'h3

`endif

// >>> hba_pkg.sv
// Types shared by the Harvard bus arbiter and peripheral bridge
`include "hba_regs.svh"

package hba_pkg;

  typedef logic [`HBA_DATA_W-1:0] hba_word_t;
  typedef logic [`HBA_NREQ-1:0] hba_src_t;

  // Program bus request (fetch, program read, program write)
  typedef struct packed {
    logic valid;
    logic wide;
    logic [`HBA_PADDR_W-1:0] addr;
    hba_word_t wdata;
  } hba_prog_req_t;

  // Data bus request (data read, data write, accelerator)
  typedef struct packed {
    logic valid;
    logic write;
    logic wide;
    logic [`HBA_DADDR_W-1:0] addr;
    hba_word_t wdata;
  } hba_req_t;

  // Command presented to a memory target
  typedef struct packed {
    logic valid;
    logic write;
    logic wide;
    logic [`HBA_PADDR_W-1:0] addr;
    hba_word_t wdata;
    hba_src_t src;
  } hba_mem_cmd_t;

  // Command presented on the peripheral bus
  typedef struct packed {
    logic valid;
    logic write;
    logic wide;
    logic [`HBA_PER_ADDR_W-1:0] addr;
    hba_word_t wdata;
    hba_src_t src;
  } hba_per_cmd_t;

endpackage

// >>> hba_arbiter_bridge.sv
// Fixed-priority memory bus arbiter with peripheral bus bridge
`timescale 1ns/1ps
`include "hba_regs.svh"

module hba_arbiter_bridge import hba_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire hba_prog_req_t fetch_req,
  input wire hba_prog_req_t pread_req,
  input wire hba_prog_req_t pwrite_req,
  input wire hba_req_t dread_req,
  input wire hba_req_t dwrite_req,
  input wire hba_req_t float_law_accelerator_req,
  output logic [`HBA_NREQ-1:0] req_ready,
  output logic [`HBA_NREQ-1:0] rsp_valid,
  output hba_word_t [`HBA_NREQ-1:0] rsp_data,
  output logic [`HBA_NREQ-1:0] rsp_err,
  output hba_mem_cmd_t [`HBA_NMEM-1:0] mem_cmd,
  input wire hba_word_t [`HBA_NMEM-1:0] mem_rdata,
  output hba_per_cmd_t per_cmd,
  input wire hba_word_t per_rdata
);

  hba_req_t req [`HBA_NREQ];
  logic [`HBA_NREQ-1:0] elig;
  logic [`HBA_NREQ-1:0] bad;
  logic [1:0] tgt [`HBA_NREQ];
  logic [1:0] frame [`HBA_NREQ];
  logic [`HBA_NREQ-1:0] cand [`HBA_NTGT];
  logic [`HBA_NREQ-1:0] grant [`HBA_NTGT];
  hba_req_t sel [`HBA_NTGT];

  hba_mem_cmd_t [`HBA_NMEM-1:0] mem_cmd_reg;
  hba_per_cmd_t per_cmd_reg;
  logic [`HBA_NREQ-1:0] rsp_valid_reg;
  hba_word_t [`HBA_NREQ-1:0] rsp_data_reg;
  logic [`HBA_NREQ-1:0] rsp_err_reg;

  // Program addresses are zero-extended so every request shares one decode
  always_comb begin
    req[`HBA_IX_DW] = dwrite_req;
    req[`HBA_IX_DW].write = 1'b1;
    req[`HBA_IX_PW] = '{valid: pwrite_req.valid, write: 1'b1, wide: pwrite_req.wide,
                        addr: {{(`HBA_DADDR_W-`HBA_PADDR_W){1'b0}}, pwrite_req.addr},
                        wdata: pwrite_req.wdata};
    req[`HBA_IX_DR] = dread_req;
    req[`HBA_IX_DR].write = 1'b0;
    req[`HBA_IX_PR] = '{valid: pread_req.valid, write: 1'b0, wide: pread_req.wide,
                        addr: {{(`HBA_DADDR_W-`HBA_PADDR_W){1'b0}}, pread_req.addr},
                        wdata: '0};
    req[`HBA_IX_IF] = '{valid: fetch_req.valid, write: 1'b0, wide: 1'b1,
                        addr: {{(`HBA_DADDR_W-`HBA_PADDR_W){1'b0}}, fetch_req.addr},
                        wdata: '0};
    req[`HBA_IX_ACC] = float_law_accelerator_req;
  end

  // Decode, refusals and bus-level exclusions
  always_comb begin
    for (int r = 0; r < `HBA_NREQ; r++) begin
      tgt[r] = req[r].addr[`HBA_TGT_MSB:`HBA_TGT_LSB];
      frame[r] = req[r].addr[`HBA_FRAME_MSB:`HBA_FRAME_LSB];
      bad[r] = 1'b0;
      if (tgt[r] == `HBA_TGT_PER) begin
        if (frame[r] != `HBA_FRAME1 && frame[r] != `HBA_FRAME2 && frame[r] != `HBA_FRAME3) begin
          bad[r] = req[r].valid;
        end
        if (frame[r] == `HBA_FRAME2 && req[r].wide) begin
          bad[r] = req[r].valid;
        end
      end
    end
    // Accelerator reaches only the shared RAM and the third frame
    if (tgt[`HBA_IX_ACC] == `HBA_TGT_PER) begin
      if (frame[`HBA_IX_ACC] != `HBA_FRAME3) begin
        bad[`HBA_IX_ACC] = req[`HBA_IX_ACC].valid;
      end
    end else if (tgt[`HBA_IX_ACC] != `HBA_TGT_SHARED) begin
      bad[`HBA_IX_ACC] = req[`HBA_IX_ACC].valid;
    end
    for (int r = 0; r < `HBA_NREQ; r++) begin
      elig[r] = req[r].valid & ~bad[r];
    end
    // Exclusions are bus-wide, not per target, so both never reach any target together
    if (req[`HBA_IX_DW].valid) begin
      elig[`HBA_IX_PW] = 1'b0;
    end
    if (req[`HBA_IX_PR].valid) begin
      elig[`HBA_IX_IF] = 1'b0;
    end
  end

  // Per-target fixed priority: lowest slot index wins
  always_comb begin
    for (int t = 0; t < `HBA_NTGT; t++) begin
      for (int r = 0; r < `HBA_NREQ; r++) begin
        cand[t][r] = elig[r] & (tgt[r] == 2'(t));
      end
      grant[t] = cand[t] & (~cand[t] + `HBA_NREQ'(1));
      sel[t] = '0;
      for (int r = 0; r < `HBA_NREQ; r++) begin
        if (grant[t][r]) begin
          sel[t] = req[r];
        end
      end
    end
  end

  // Losers see ready low and must hold their request; refused ones are taken and dropped
  always_comb begin
    for (int r = 0; r < `HBA_NREQ; r++) begin
      req_ready[r] = clk_en & (bad[r] | grant[0][r] | grant[1][r] | grant[2][r] | grant[3][r]);
    end
  end

  // One command per target per cycle; every target runs in parallel
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mem_cmd_reg <= '0;
    end else if (clk_en) begin
      for (int t = 0; t < `HBA_NMEM; t++) begin
        mem_cmd_reg[t].valid <= |grant[t];
        mem_cmd_reg[t].write <= sel[t].write;
        mem_cmd_reg[t].wide <= sel[t].wide;
        mem_cmd_reg[t].addr <= sel[t].addr[`HBA_PADDR_W-1:0];
        mem_cmd_reg[t].wdata <= sel[t].wdata;
        mem_cmd_reg[t].src <= grant[t];
      end
    end
  end

  // Bridge: the peripheral window is narrowed to a 16-bit address
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      per_cmd_reg <= '0;
    end else if (clk_en) begin
      per_cmd_reg.valid <= |grant[`HBA_TGT_PER];
      per_cmd_reg.write <= sel[`HBA_TGT_PER].write;
      per_cmd_reg.wide <= sel[`HBA_TGT_PER].wide;
      per_cmd_reg.addr <= sel[`HBA_TGT_PER].addr[`HBA_PER_ADDR_W-1:0];
      per_cmd_reg.wdata <= sel[`HBA_TGT_PER].wdata;
      per_cmd_reg.src <= grant[`HBA_TGT_PER];
    end
  end

  // Read data returns the cycle after the target sees the command
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid_reg <= '0;
      rsp_data_reg <= '0;
    end else if (clk_en) begin
      for (int r = 0; r < `HBA_NREQ; r++) begin
        rsp_valid_reg[r] <= 1'b0;
        for (int t = 0; t < `HBA_NMEM; t++) begin
          if (mem_cmd_reg[t].valid && !mem_cmd_reg[t].write && mem_cmd_reg[t].src[r]) begin
            rsp_valid_reg[r] <= 1'b1;
            rsp_data_reg[r] <= mem_rdata[t];
          end
        end
        if (per_cmd_reg.valid && !per_cmd_reg.write && per_cmd_reg.src[r]) begin
          rsp_valid_reg[r] <= 1'b1;
          // Narrow peripheral reads return zero in the upper half
          rsp_data_reg[r] <= per_cmd_reg.wide ? per_rdata :
                             {{`HBA_HALF_W{1'b0}}, per_rdata[`HBA_HALF_W-1:0]};
        end
      end
    end
  end

  // Refused accesses report a one-cycle error instead of stalling the core
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rsp_err_reg <= '0;
    end else if (clk_en) begin
      rsp_err_reg <= bad;
    end
  end

  assign mem_cmd = mem_cmd_reg;
  assign per_cmd = per_cmd_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign rsp_err = rsp_err_reg;

  // Helper terms read only by the checks below
  logic dw_issued;
  logic [`HBA_NREQ-1:0] any_issued;
  always_comb begin
    any_issued = per_cmd_reg.valid ? per_cmd_reg.src : '0;
    for (int t = 0; t < `HBA_NMEM; t++) begin
      if (mem_cmd_reg[t].valid) begin
        any_issued = any_issued | mem_cmd_reg[t].src;
      end
    end
    dw_issued = any_issued[`HBA_IX_DW];
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_dr_taken;
    req_ready[`HBA_IX_DR] && !bad[`HBA_IX_DR] && clk_en;
  endsequence

  sequence s_two_live;
    clk_en ##1 clk_en;
  endsequence

  chk_dw_pw_excl: assert property (
    !(req_ready[`HBA_IX_PW] && dwrite_req.valid))
    else $error("program write granted beside a data write");

  chk_pr_if_excl: assert property (
    !(req_ready[`HBA_IX_IF] && pread_req.valid))
    else $error("fetch granted beside a program read");

  chk_dw_over_dr: assert property (
    dwrite_req.valid && !bad[`HBA_IX_DW] && tgt[`HBA_IX_DW] == tgt[`HBA_IX_DR]
      |-> !req_ready[`HBA_IX_DR] || bad[`HBA_IX_DR])
    else $error("data read beat a data write to the same target");

  chk_read_return: assert property (
    s_dr_taken ##0 s_two_live |=> rsp_valid[`HBA_IX_DR])
    else $error("data read did not return two cycles after grant");

  chk_write_issue: assert property (
    req_ready[`HBA_IX_DW] && !bad[`HBA_IX_DW] |=> dw_issued && $past(dwrite_req.wide) ==
      ((mem_cmd_reg[0].valid && mem_cmd_reg[0].src[`HBA_IX_DW]) ? mem_cmd_reg[0].wide :
       (mem_cmd_reg[1].valid && mem_cmd_reg[1].src[`HBA_IX_DW]) ? mem_cmd_reg[1].wide :
       (mem_cmd_reg[2].valid && mem_cmd_reg[2].src[`HBA_IX_DW]) ? mem_cmd_reg[2].wide :
       per_cmd_reg.wide))
    else $error("granted data write not issued whole next cycle");

  chk_frame2_narrow: assert property (
    per_cmd.valid && per_cmd.addr[`HBA_FRAME_MSB:`HBA_FRAME_LSB] == `HBA_FRAME2 |-> !per_cmd.wide)
    else $error("wide access reached the second frame");

  chk_acc_frames: assert property (
    per_cmd.valid && per_cmd.src[`HBA_IX_ACC]
      |-> per_cmd.addr[`HBA_FRAME_MSB:`HBA_FRAME_LSB] == `HBA_FRAME3)
    else $error("accelerator reached a frame other than the third");

  chk_loser_blocked: assert property (
    clk_en && elig[`HBA_IX_IF] && !req_ready[`HBA_IX_IF]
      |-> |(cand[tgt[`HBA_IX_IF]][`HBA_IX_PR:`HBA_IX_DW]))
    else $error("fetch held off with no higher contender");

  chk_concurrent: assert property (
    clk_en && elig[`HBA_IX_IF] && elig[`HBA_IX_DR] && elig[`HBA_IX_DW] &&
      !elig[`HBA_IX_PW] && !elig[`HBA_IX_PR] && !elig[`HBA_IX_ACC] &&
      tgt[`HBA_IX_IF] != tgt[`HBA_IX_DR] && tgt[`HBA_IX_IF] != tgt[`HBA_IX_DW] &&
      tgt[`HBA_IX_DR] != tgt[`HBA_IX_DW]
      |-> req_ready[`HBA_IX_IF] && req_ready[`HBA_IX_DR] && req_ready[`HBA_IX_DW])
    else $error("independent fetch, read and write not granted together");

  sequence s_dr_refused;
    req_ready[`HBA_IX_DR] && bad[`HBA_IX_DR];
  endsequence

  // Exclusions are checked again where the commands leave, across all targets
  chk_bus_dw_pw: assert property (
    !(any_issued[`HBA_IX_DW] && any_issued[`HBA_IX_PW]))
    else $error("data write and program write issued together");

  chk_bus_pr_if: assert property (
    !(any_issued[`HBA_IX_PR] && any_issued[`HBA_IX_IF]))
    else $error("program read and fetch issued together");

  chk_refuse_err: assert property (
    s_dr_refused |=> rsp_err[`HBA_IX_DR] && !any_issued[`HBA_IX_DR])
    else $error("refused data read did not report an error");

  chk_loser_silent: assert property (
    clk_en && elig[`HBA_IX_DR] && !req_ready[`HBA_IX_DR] |=> !any_issued[`HBA_IX_DR])
    else $error("held data read reached a target");

  chk_per_single: assert property (
    per_cmd.valid |-> $onehot(per_cmd.src))
    else $error("peripheral command without a single source");

  chk_mem_single: assert property (
    mem_cmd[`HBA_TGT_SHARED].valid |-> $onehot(mem_cmd[`HBA_TGT_SHARED].src))
    else $error("shared memory command without a single source");

  chk_narrow_zero: assert property (
    clk_en && per_cmd.valid && !per_cmd.write && !per_cmd.wide && per_cmd.src[`HBA_IX_DR]
      |=> rsp_data[`HBA_IX_DR][`HBA_DATA_W-1:`HBA_HALF_W] == '0)
    else $error("narrow peripheral read left upper half set");

  // Any accelerator access that is not on the peripheral bus must be on the shared RAM
  chk_acc_shared: assert property (
    any_issued[`HBA_IX_ACC] && !(per_cmd.valid && per_cmd.src[`HBA_IX_ACC])
      |-> mem_cmd[`HBA_TGT_SHARED].valid && mem_cmd[`HBA_TGT_SHARED].src[`HBA_IX_ACC])
    else $error("accelerator reached a memory it may not use");

endmodule

// >>> hba_target_model.sv
// Memory and peripheral targets answering the arbiter's commands
`timescale 1ns/1ps
`include "hba_regs.svh"

module hba_target_model import hba_pkg::*; (
  input wire logic ref_clk,
  input wire hba_mem_cmd_t [`HBA_NMEM-1:0] mem_cmd,
  input wire hba_per_cmd_t per_cmd,
  output hba_word_t [`HBA_NMEM-1:0] mem_rdata,
  output hba_word_t per_rdata
);
  logic [31:0] noise = 32'h0;
  // Idle data churns every cycle so a stale word can never pass for read data
  always @(posedge ref_clk) noise <= noise + 32'h9E3779B9;
  always_comb begin
    for (int t = 0; t < `HBA_NMEM; t++) begin
      // Answer in the same cycle as the command, tagged by target
      mem_rdata[t] = (mem_cmd[t].valid && !mem_cmd[t].write) ?
        {6'h28, t[1:0], 2'h0, mem_cmd[t].addr} : noise ^ t;
    end
    per_rdata = (per_cmd.valid && !per_cmd.write) ? {16'h5A5A, per_cmd.addr} : ~noise;
  end
endmodule

// >>> tb_top.sv
// Self-checking bench for the arbiter and peripheral bridge
`timescale 1ns/1ps
`include "hba_regs.svh"

module tb_top import hba_pkg::*;;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  hba_prog_req_t fe = '0, pr = '0, pw = '0;
  hba_req_t dr = '0, dw = '0, ac = '0;
  logic [5:0] rdy, rv, re;
  hba_word_t [5:0] rd;
  hba_mem_cmd_t [2:0] mc;
  hba_word_t [2:0] mrd;
  hba_per_cmd_t pc;
  hba_word_t prd;
  int n_fail = 0;
  int tests_run = 0;

  hba_arbiter_bridge hba_arbiter_bridge_i (.ref_clk(ref_clk), .resetn(resetn),
    .clk_en(clk_en), .fetch_req(fe), .pread_req(pr), .pwrite_req(pw), .dread_req(dr),
    .dwrite_req(dw), .float_law_accelerator_req(ac), .req_ready(rdy), .rsp_valid(rv),
    .rsp_data(rd), .rsp_err(re), .mem_cmd(mc), .mem_rdata(mrd), .per_cmd(pc),
    .per_rdata(prd));
  hba_target_model hba_target_model_i (.ref_clk(ref_clk), .mem_cmd(mc), .per_cmd(pc),
    .mem_rdata(mrd), .per_rdata(prd));

  initial forever #10 ref_clk = ~ref_clk;

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Drive one requester slot; called just after a rising edge
  task automatic go(input int r, input logic [31:0] a, input logic w, input logic v);
    case (r)
      0: dw <= '{v, 1'b1, w, a, 32'h1234ABCD};
      1: pw <= '{v, w, a[21:0], 32'h0F0F0F0F};
      2: dr <= '{v, 1'b0, w, a, 32'h0};
      3: pr <= '{v, w, a[21:0], 32'h0};
      4: fe <= '{v, 1'b1, a[21:0], 32'h0};
      default: ac <= '{v, 1'b0, w, a, 32'h0};
    endcase
  endtask

  // One read, expecting either refusal or the given data
  task automatic rd_one(input int r, input logic [31:0] a, input logic w,
                        input logic err, input logic [31:0] exp);
    int i;
    @(posedge ref_clk) go(r, a, w, 1'b1);
    @(negedge ref_clk);
    for (i = 0; i < 20 && rdy[r] !== 1'b1; i++) @(negedge ref_clk);
    @(posedge ref_clk) go(r, a, w, 1'b0);
    @(negedge ref_clk) chk("rsp_err", re[r], err);
    if (!err) begin
      @(negedge ref_clk) chk("rsp_valid", rv[r], 1'b1);
      chk("rsp_data", rd[r], exp);
    end
  endtask

  task automatic t_periph();
    // Frame widths and which requesters each frame admits
    int rs[8] = '{2, 2, 2, 2, 5, 5, 5, 5};
    logic [31:0] as[8] = '{32'h34010, 32'h38010, 32'h38020, 32'h30000, 32'h3C004,
                           32'h34000, 32'h00008, 32'h10008};
    logic [7:0] ws = 8'b10110011;
    logic [7:0] es = 8'b01101010;
    logic [31:0] ds[8] = '{32'h5A5A4010, 0, 32'h00008020, 0, 32'h5A5AC004, 0, 0,
                           32'hA1010008};
    for (int k = 0; k < 8; k++) begin
      rd_one(rs[k], as[k], ws[k], es[k], ds[k]);
    end
  endtask

  task automatic t_parallel();
    @(posedge ref_clk);
    go(4, 32'h00040, 1'b1, 1'b1);
    go(2, 32'h20010, 1'b1, 1'b1);
    go(0, 32'h10004, 1'b1, 1'b1);
    @(negedge ref_clk) chk("ready", rdy, 6'b010101);
    @(posedge ref_clk);
    go(4, 0, 1'b1, 1'b0);
    go(2, 0, 1'b1, 1'b0);
    go(0, 0, 1'b1, 1'b0);
    @(negedge ref_clk) chk("dw cmd", {mc[1].valid, mc[1].write, mc[1].src}, 8'hC1);
    chk("dw addr", mc[1].addr, 32'h10004);
    chk("dw wdata", mc[1].wdata, 32'h1234ABCD);
    @(negedge ref_clk) chk("rv", rv, 6'b010100);
    chk("dr data", rd[2], {8'hA2, 2'h0, 22'h020010});
    chk("if data", rd[4], {8'hA0, 2'h0, 22'h000040});
  endtask

  task automatic t_priority();
    @(posedge ref_clk);
    for (int r = 0; r < 5; r++) go(r, 32'h00100 + r, 1'b1, 1'b1);
    for (int k = 0; k < 5; k++) begin
      @(negedge ref_clk) chk("grant", rdy[4:0], 5'b1 << k);
      @(posedge ref_clk) go(k, 0, 1'b1, 1'b0);
    end
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic t_stall();
    @(posedge ref_clk) clk_en <= 1'b0;
    go(2, 32'h00200, 1'b1, 1'b1);
    @(negedge ref_clk) chk("frozen", rdy[2], 1'b0);
    @(posedge ref_clk) clk_en <= 1'b1;
    @(negedge ref_clk) chk("resumed", rdy[2], 1'b1);
    @(posedge ref_clk) go(2, 0, 1'b1, 1'b0);
    @(negedge ref_clk) chk("held cmd", {mc[0].valid, mc[0].src}, 7'h44);
    @(negedge ref_clk) chk("held rv", rv[2], 1'b1);
    chk("held data", rd[2], {8'hA0, 2'h0, 22'h000200});
  endtask

  // Peripheral write, then a narrow program write to memory
  task automatic t_writes();
    @(posedge ref_clk) go(0, 32'h34020, 1'b1, 1'b1);
    @(negedge ref_clk) chk("dw ready", rdy[0], 1'b1);
    @(posedge ref_clk) go(0, 0, 1'b1, 1'b0);
    go(1, 32'h00300, 1'b0, 1'b1);
    @(negedge ref_clk) chk("per cmd", {pc.valid, pc.write, pc.wide, pc.addr}, 19'h74020);
    chk("per wdata", pc.wdata, 32'h1234ABCD);
    chk("per src", pc.src, 6'h01);
    chk("pw ready", rdy[1], 1'b1);
    @(posedge ref_clk) go(1, 0, 1'b0, 1'b0);
    @(negedge ref_clk) chk("pw cmd", {mc[0].valid, mc[0].write, mc[0].wide, mc[0].src}, 9'h182);
    chk("pw addr", mc[0].addr, 32'h300);
    chk("pw wdata", mc[0].wdata, 32'h0F0F0F0F);
    chk("per idle", pc.valid, 1'b0);
  endtask

  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    t_parallel();
    t_priority();
    t_stall();
    t_writes();
    t_periph();
    repeat (2) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule
